// >>> rtl/lds_shift_latch.sv
`include "lds_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Shift only on rising serial clock edges
// [R2] Error mode: clock edges step diagnostic modes
// [R3] Serial out trails input 8.5 clocks
// [R4] Enable low lets drivers sink, always
// [R5] Global mode: serial out low on fault
// [R6] Separate data register holds shown pattern
// [R7] Load stores global summary and detail results
// [R8] Detect temp, open, short; serial read-back
// [R9] Reduced current while in error mode
// [R10] 16-bit shift, load rise copies to data
// [R11] Channel sinks when bit one, enable low
module lds_shift_latch #(
   parameter int unsigned CH = `LDS_CHANNELS,
   parameter int unsigned TAP = `LDS_OUT_TAP
) (
   input wire logic clock_i,                 // System clock, 200 MHz
   input wire logic rst_n_i,                 // Async reset, active low
   input wire logic ce_i,                    // Clock enable, freezes state when low
   input wire logic serial_clk_i,            // Serial clock pin
   input wire logic serial_in_i,             // Serial data pin
   input wire logic load_strobe_i,           // Load pin
   input wire logic drive_enable_n_i,        // Output enable pin, active low
   input wire logic error_mode_i,            // High selects error mode
   input wire logic [CH-1:0] open_fault_i,   // Open-LED comparators
   input wire logic [CH-1:0] short_fault_i,  // Shorted-LED comparators
   input wire logic over_temp_i,             // Over-temperature sensor
   output logic serial_out_o,                // Serial data / fault flag
   output logic [CH-1:0] sink_channels_o,    // Per-channel sink enables
   output logic low_current_o                // Reduced drive current
);
   import lds_pkg::*;

   //////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   localparam int unsigned SW = 2 * CH + 6;
   localparam logic [SW-1:0] SYNC_RST = {{(SW - 4){1'b0}}, `LDS_RST_OEN, 3'h0};

   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic clk_prev;
   logic load_prev;

   // Every pin, serial data included, crosses at the same depth so data and clock stay aligned
   wire [SW-1:0] pin_bus = {over_temp_i,
                            short_fault_i,
                            open_fault_i,
                            error_mode_i,
                            drive_enable_n_i,
                            load_strobe_i,
                            serial_in_i,
                            serial_clk_i};

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync1 <= SYNC_RST;
         sync2 <= SYNC_RST;
      end
      else if (ce_i)
      begin
         sync1 <= pin_bus;
         sync2 <= sync1;
      end
   end

   // History taken after the second stage, so no edge comes from a metastable flop
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         clk_prev <= 1'b0;
         load_prev <= 1'b0;
      end
      else if (ce_i)
      begin
         clk_prev <= sync2[0];
         load_prev <= sync2[2];
      end
   end

   wire s_clk = sync2[0];
   wire s_din = sync2[1];
   wire s_load = sync2[2];
   wire s_oen = sync2[3];
   wire s_err = sync2[4];
   wire [CH-1:0] s_open = sync2[5 +: CH];
   wire [CH-1:0] s_short = sync2[5 + CH +: CH];
   wire s_temp = sync2[SW-1];

   wire clk_rise = s_clk & ~clk_prev;   // [R1]
   wire clk_fall = ~s_clk & clk_prev;
   wire load_rise = s_load & ~load_prev; // [R10]

   //////////////////////////////////////////////////////////////////////////////
   // Mode sequencing
   lds_mode_t mode;
   lds_mode_t next_mode;

   wire normal = (mode == LDS_NORMAL);
   wire mode_global = (mode == LDS_ERR_GLOBAL);
   wire mode_open = (mode == LDS_ERR_OPEN);
   wire mode_short = (mode == LDS_ERR_SHORT);
   wire mode_temp = (mode == LDS_ERR_TEMP);
   wire next_low = (next_mode != LDS_NORMAL); // [R9]

   // Leaving error mode needs no serial clock; the cascade output keeps its last bit

   always_comb
   begin
      next_mode = mode;
      if (!s_err)
         next_mode = LDS_NORMAL;
      else if (mode == LDS_NORMAL)
         next_mode = LDS_ERR_GLOBAL;
      else if (clk_rise)
      begin
         case (mode)                    // [R2]
            LDS_ERR_GLOBAL: next_mode = LDS_ERR_OPEN;
            LDS_ERR_OPEN: next_mode = LDS_ERR_SHORT;
            LDS_ERR_SHORT: next_mode = LDS_ERR_TEMP;
            LDS_ERR_TEMP: next_mode = LDS_ERR_GLOBAL;
            default: next_mode = LDS_ERR_GLOBAL;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Stored results
   logic [CH-1:0] shift_reg;
   logic [CH-1:0] data_reg;
   logic [CH-1:0] open_reg;
   logic [CH-1:0] short_reg;
   logic temp_reg;
   logic fault_reg;

   wire load_normal = load_rise & normal;

   // Captured in normal mode only, so a diagnostic read-back never disturbs the display
   lds_diag_regs #(.CH(CH)) u_regs (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .load_i(load_normal),
      .data_i(shift_reg),
      .open_i(s_open),
      .short_i(s_short),
      .temp_i(s_temp),
      .data_o(data_reg),   // [R6]
      .open_o(open_reg),
      .short_o(short_reg),
      .temp_o(temp_reg),
      .fault_o(fault_reg)  // [R7]
   );

   // Detail result chosen for read-back by a load in the open, short or temperature mode
   wire [CH-1:0] detail_sel = mode_open ? open_reg :
                              mode_short ? short_reg :
                              {{(CH - 1){1'b0}}, temp_reg};
   wire load_detail = load_rise & (mode_open | mode_short | mode_temp);

   wire [CH-1:0] shifted = {shift_reg[CH-2:0], s_din};
   wire [CH-1:0] next_shift = load_detail ? detail_sel :                 // [R8]
                              (clk_rise && normal) ? shifted : shift_reg; // [R1] [R10]
   wire next_out = mode_global ? ~fault_reg :                            // [R5]
                   (clk_fall && normal) ? shift_reg[TAP] : serial_out_o; // [R3]

   // One gate per channel; the enable overrides the data in every mode
   wire [CH-1:0] next_sink;
   genvar gi;
   generate
      for (gi = 0; gi < CH; gi++)
      begin : g_sink
         assign next_sink[gi] = data_reg[gi] & ~s_oen; // [R4] [R11]
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // Mode and drive current
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode <= LDS_NORMAL;
         low_current_o <= 1'b0;
      end
      else if (ce_i)
      begin
         mode <= next_mode;
         low_current_o <= next_low; // [R9]
      end
   end

   // Shift register
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         shift_reg <= CH'(`LDS_RST_WORD);
      end
      else if (ce_i)
      begin
         shift_reg <= next_shift;
      end
   end

   // Outputs
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         serial_out_o <= `LDS_RST_SERIAL_OUT;
         sink_channels_o <= CH'(`LDS_RST_WORD);
      end
      else if (ce_i)
      begin
         serial_out_o <= next_out;
         sink_channels_o <= next_sink;
      end
   end
endmodule

// >>> rtl/lds_map.svh
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH
// Channel count and width of the shift and data registers
`define LDS_CHANNELS 16
// Shift stage feeding the cascade output, latched on the falling serial clock edge
`define LDS_OUT_TAP 8
// Reset values
`define LDS_RST_SERIAL_OUT 1'b1
`define LDS_RST_OEN 1'b1
`define LDS_RST_WORD 16'h0000
`endif

// >>> rtl/lds_pkg.sv
package lds_pkg;
   typedef enum logic [2:0]
   {
      LDS_NORMAL,
      LDS_ERR_GLOBAL,
      LDS_ERR_OPEN,
      LDS_ERR_SHORT,
      LDS_ERR_TEMP
   } lds_mode_t;
endpackage

// >>> rtl/lds_diag_regs.sv
`include "lds_map.svh"
module lds_diag_regs #(
   parameter int unsigned CH = `LDS_CHANNELS
) (
   input wire logic clock_i,            // System clock
   input wire logic rst_n_i,            // Async reset, active low
   input wire logic ce_i,               // Clock enable
   input wire logic load_i,             // One-cycle load pulse
   input wire logic [CH-1:0] data_i,    // Shift register contents
   input wire logic [CH-1:0] open_i,    // Open-LED flags
   input wire logic [CH-1:0] short_i,   // Shorted-LED flags
   input wire logic temp_i,             // Over-temperature flag
   output logic [CH-1:0] data_o,        // Displayed pattern
   output logic [CH-1:0] open_o,        // Stored open-LED result
   output logic [CH-1:0] short_o,       // Stored shorted-LED result
   output logic temp_o,                 // Stored over-temperature result
   output logic fault_o                 // Stored global fault summary
);
   import lds_pkg::*;

   wire any_fault = (|open_i) | (|short_i) | temp_i;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data_o <= CH'(`LDS_RST_WORD);
         open_o <= CH'(`LDS_RST_WORD);
         short_o <= CH'(`LDS_RST_WORD);
         temp_o <= 1'b0;
         fault_o <= 1'b0;
      end
      else if (ce_i && load_i)
      begin
         data_o <= data_i;     // [R6] [R10]
         open_o <= open_i;     // [R7] [R8]
         short_o <= short_i;   // [R7] [R8]
         temp_o <= temp_i;     // [R7] [R8]
         fault_o <= any_fault; // [R7]
      end
   end
endmodule

// >>> dv/lds_host.sv
module lds_host (
   output logic serial_clk_o, // Serial clock
   output logic serial_in_o, // Serial data
   output logic load_strobe_o // Load pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      serial_clk_o = 1'b0;
      serial_in_o = 1'b0;
      load_strobe_o = 1'b0;
   end
   ////////////////////////////////////////
   // Data set at the falling edge, a whole low phase before the rise, so it is stable across the rise
   task automatic cycle(input logic b);
      serial_in_o <= b;
      #32 serial_clk_o <= 1'b1;
      #32 serial_clk_o <= 1'b0;
   endtask
   task automatic send(input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         cycle(w[i]);
      // Released line must not keep the last bit
      #32 serial_in_o <= ~w[0];
   endtask
   task automatic tick(input int n);
      repeat (n)
         cycle(~serial_in_o);
   endtask
   task automatic load();
      #16 load_strobe_o <= 1'b1;
      #64 load_strobe_o <= 1'b0;
      #64;
   endtask
endmodule

// >>> dv/lds_props_properties.sv
module lds_props #(
   parameter int unsigned CH = 16,
   parameter int unsigned TAP = 8
) (
   input wire logic clock_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic ce_i, // Enable
   input wire logic serial_clk_i, // Serial clock
   input wire logic serial_in_i, // Serial data
   input wire logic load_strobe_i, // Load
   input wire logic drive_enable_n_i, // Drive enable
   input wire logic error_mode_i, // Error mode
   input wire logic [CH-1:0] open_fault_i, // Open flags
   input wire logic [CH-1:0] short_fault_i, // Short flags
   input wire logic over_temp_i, // Temp flag
   input wire logic serial_out_o, // Serial out
   input wire logic [CH-1:0] sink_channels_o, // Sinks
   input wire logic low_current_o // Low current
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   // Pin paths are two synchroniser flops plus an output flop, hence the figures of 3
   oen_off_a: assert property ((ce_i && drive_enable_n_i)[*4] |-> sink_channels_o == '0)
      else $error("sinks active with enable high");
   oen_cause_a: assert property (sink_channels_o != '0 |-> !$past(drive_enable_n_i, 3))
      else $error("sink active without enable low");
   mode_low_a: assert property ((ce_i && !error_mode_i)[*4] |-> !low_current_o)
      else $error("low current outside error mode");
   mode_err_a: assert property ((ce_i && error_mode_i)[*4] |-> low_current_o)
      else $error("full current in error mode");
   cur_rise_a: assert property ($rose(low_current_o) |-> $past(error_mode_i, 3))
      else $error("error mode entered late or early");
   cur_fall_a: assert property ($fell(low_current_o) |-> !$past(error_mode_i, 3))
      else $error("error mode left late or early");
   // Mode entry reloads the output, so three quiet cycles are required
   shift_edge_a: assert property (!low_current_o && !$past(low_current_o) && !$past(low_current_o, 2)
      && $changed(serial_out_o) |-> $past(serial_clk_i, 4) && !$past(serial_clk_i, 3))
      else $error("cascade output moved off a serial clock fall");
   rst_val_a: assert property ($rose(rst_n_i) |-> serial_out_o && sink_channels_o == '0)
      else $error("wrong value after reset");
   load_c: cover property ($rose(load_strobe_i) && !error_mode_i);
   err_c: cover property ($rose(low_current_o));
   sink_c: cover property (sink_channels_o != '0);
endmodule
bind lds_shift_latch lds_props #(.CH(CH), .TAP(TAP)) i_props (.*);

// >>> dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i, sclk, sdat, ld, sout, lowc;
   logic rst_n_i = 1'b0, oen_n = 1'b1, err_mode = 1'b0, otemp = 1'b0, ce = 1'b1;
   logic [15:0] open_f = 16'h0000, short_f = 16'h0000, sink;
   int n_fail = 0, tests_run = 0, cycles = 0;
   lds_host i_host (.serial_clk_o(sclk), .serial_in_o(sdat), .load_strobe_o(ld));
   lds_shift_latch i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .serial_clk_i(sclk),
      .serial_in_i(sdat), .load_strobe_i(ld), .drive_enable_n_i(oen_n), .error_mode_i(err_mode),
      .open_fault_i(open_f), .short_fault_i(short_f), .over_temp_i(otemp), .serial_out_o(sout),
      .sink_channels_o(sink), .low_current_o(lowc));
   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   ////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle();
      repeat (8) @(posedge clock_i);
      #1;
   endtask
   task automatic t_load();
      i_host.send(16'hA5C3);
      check("cascade", 16'h0001, {15'h0000, sout});
      i_host.load();
      @(posedge clock_i) oen_n <= 1'b0;
      settle();
      check("sinks", 16'hA5C3, sink);
      i_host.send(16'h5E7A);
      check("held", 16'hA5C3, sink);
      check("cascade", 16'h0000, {15'h0000, sout});
      // A load pulse inside a clock-enable pause must be lost
      @(posedge clock_i) ce <= 1'b0;
      i_host.load();
      @(posedge clock_i) ce <= 1'b1;
      settle();
      check("frozen", 16'hA5C3, sink);
      @(posedge clock_i) oen_n <= 1'b1;
      settle();
      check("gated", 16'h0000, sink);
   endtask
   task automatic t_diag();
      @(posedge clock_i) oen_n <= 1'b0;
      open_f <= 16'h0080;
      short_f <= 16'h0040;
      otemp <= 1'b1;
      settle();
      i_host.load();
      @(posedge clock_i) err_mode <= 1'b1;
      settle();
      check("fault flag", 16'h0000, {15'h0000, sout});
      check("low current", 16'h0001, {15'h0000, lowc});
      check("sinks in error", 16'h5E7A, sink);
      i_host.tick(4);
      check("mode wrap", 16'h0000, {15'h0000, sout});
      i_host.tick(1);
      i_host.load();
      @(posedge clock_i) err_mode <= 1'b0;
      settle();
      i_host.tick(1);
      settle();
      check("open readback", 16'h0001, {15'h0000, sout});
      check("data kept", 16'h5E7A, sink);
      // Short flag sits at bit 6, two shifts below the tap
      @(posedge clock_i) err_mode <= 1'b1;
      settle();
      i_host.tick(2);
      i_host.load();
      @(posedge clock_i) err_mode <= 1'b0;
      settle();
      i_host.tick(2);
      settle();
      check("short readback", 16'h0001, {15'h0000, sout});
      // Temperature result sits at bit 0, eight shifts below the tap
      @(posedge clock_i) err_mode <= 1'b1;
      settle();
      i_host.tick(3);
      i_host.load();
      @(posedge clock_i) err_mode <= 1'b0;
      settle();
      i_host.tick(8);
      settle();
      check("temp readback", 16'h0001, {15'h0000, sout});
      check("data still kept", 16'h5E7A, sink);
      @(posedge clock_i) open_f <= 16'h0000;
      short_f <= 16'h0000;
      otemp <= 1'b0;
      settle();
      i_host.load();
      @(posedge clock_i) err_mode <= 1'b1;
      settle();
      check("no fault flag", 16'h0001, {15'h0000, sout});
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs about a thousand cycles
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      settle();
      t_load();
      t_diag();
      complete_run();
   end
endmodule
